// File: hdl/rdc_init_pkg.sv
// Shared constants and types for the resolver converter start-up sequencer.
// Assumes the converter takes register accesses over a four-phase req/ack handshake.
package rdc_init_pkg;

  // ----------------------------------------------------------------------
  // Clock and documented wait times
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned INIT_WAIT_US    = 900;
  localparam int unsigned ADCCAL_WAIT_US  = 210;
  localparam int unsigned TABLE_WAIT_MS   = 20;
  localparam int unsigned INTEG_WAIT_MS   = 5;
  localparam int unsigned ERRDET_WAIT_MS  = 26;

  // Least times: round up to whole cycles
  function automatic int unsigned us_to_cyc(input int unsigned hz, input int unsigned us);
    longint unsigned c;
    c = (longint'(hz) * us + 64'd999_999) / 64'd1_000_000;
    return (c < 1) ? 1 : int'(c);
  endfunction

  localparam int unsigned INIT_WAIT_CYC   = us_to_cyc(CLK_HZ, INIT_WAIT_US);
  localparam int unsigned ADCCAL_WAIT_CYC = us_to_cyc(CLK_HZ, ADCCAL_WAIT_US);
  localparam int unsigned TABLE_WAIT_CYC  = us_to_cyc(CLK_HZ, TABLE_WAIT_MS * 1000);
  localparam int unsigned INTEG_WAIT_CYC  = us_to_cyc(CLK_HZ, INTEG_WAIT_MS * 1000);
  localparam int unsigned ERRDET_WAIT_CYC = us_to_cyc(CLK_HZ, ERRDET_WAIT_MS * 1000);

  // ----------------------------------------------------------------------
  // Converter register word addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] EXCITATION_SELECT_REG = 8'h00;
  localparam logic [7:0] LOOP_GAIN_REG_A       = 8'h01;
  localparam logic [7:0] LOOP_GAIN_REG_B       = 8'h02;
  localparam logic [7:0] ERROR_CONFIG_REG_A    = 8'h03;
  localparam logic [7:0] ERROR_CONFIG_REG_B    = 8'h04;
  localparam logic [7:0] DIGITAL_CALC_REG      = 8'h05;
  localparam logic [7:0] MONITOR_GAIN_CTRL_REG = 8'h06;
  localparam logic [7:0] ANALOG_RUN_CTRL_REG   = 8'h07;
  localparam logic [7:0] ADC_CAL_SETTING_REG   = 8'h08;
  localparam logic [7:0] ADC_CAL_CTRL_REG      = 8'h09;
  localparam logic [7:0] TABLE_CORRECTION_REG  = 8'h0A;

  // ----------------------------------------------------------------------
  // Configuration words
  // ----------------------------------------------------------------------
  localparam logic [31:0] EXCITATION_10K_VAL = 32'h0B0F0410;
  localparam logic [31:0] LOOP_GAIN_A_VAL    = 32'h00020017;
  localparam logic [31:0] LOOP_GAIN_B_VAL    = 32'h00011B01;
  localparam logic [31:0] ERROR_CFG_A_VAL    = 32'h021A2933;
  localparam logic [31:0] ERROR_CFG_B_VAL    = 32'hB0000000;
  localparam logic [31:0] DIGITAL_CALC_VAL   = 32'h00020024;
  localparam logic [31:0] ZERO_VAL           = 32'h00000000;

  // ----------------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned MONITOR_OUT_EN_BIT          = 0;
  localparam int unsigned AMP_UNITY_GAIN_BIT          = 1;
  localparam int unsigned ANALOG_STOP_BIT             = 0;
  localparam int unsigned INIT_REQUEST_BIT            = 0;
  localparam int unsigned INTEGRATOR_RESET_BIT        = 1;
  localparam int unsigned ERROR_DETECT_ENABLE_BIT     = 2;
  localparam int unsigned ERROR_STATUS_RESET_BIT      = 3;
  localparam int unsigned AMP_INVERT_BIT              = 8;
  localparam int unsigned ADC_CAL_START_BIT           = 0;
  localparam int unsigned TABLE_CORRECTION_ENABLE_BIT = 0;
  localparam int unsigned TABLE_CORRECTION_START_BIT  = 1;

  localparam logic [4:0] LAST_STEP = 5'h17;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_POLL  = 2'b01,
    OP_WAIT  = 2'b10
  } op_e;

  typedef enum logic [2:0] {
    W_INIT   = 3'b000,
    W_ADCCAL = 3'b001,
    W_TABLE  = 3'b010,
    W_INTEG  = 3'b011,
    W_ERRDET = 3'b100
  } wait_sel_e;

  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dev_cmd_s;

  typedef struct packed {
    op_e         op;
    wait_sel_e   wsel;
    logic [7:0]  addr;
    logic [31:0] data;
  } step_s;

endpackage

// File: hdl/rdc_init_seq.sv
// Host-side sequencer that brings the resolver converter out of reset.
// Assumes the converter answers each access with a four-phase req/ack handshake
// and holds its read data stable while ack is high.
//
// Contract
// RL1: First write excitation select for 10 kHz.
// RL2: Program loop gains: automatic adjust, 12-bit.
// RL3: Load both error configuration words next.
// RL4: Write digital calc word, enable monitor output.
// RL5: Clear analog stop before requesting initialization.
// RL6: Set init request, then wait 900 us.
// RL7: Poll init request until converter clears it.
// RL8: Zero calibration setting, start calibration, 210 us.
// RL9: Enable table correction, start it, wait 20 ms.
// RL10: Unity gain, integrator reset, wait 5 ms.
// RL11: Then set amplifier inversion.
// RL12: Error detect on, wait 26 ms, reset status.
// RL13: Waits counted in clock cycles, then advance.
`timescale 1ns/100ps
`default_nettype none

module rdc_init_seq #(
  parameter int unsigned INIT_WAIT_CYC   = rdc_init_pkg::INIT_WAIT_CYC,
  parameter int unsigned ADCCAL_WAIT_CYC = rdc_init_pkg::ADCCAL_WAIT_CYC,
  parameter int unsigned TABLE_WAIT_CYC  = rdc_init_pkg::TABLE_WAIT_CYC,
  parameter int unsigned INTEG_WAIT_CYC  = rdc_init_pkg::INTEG_WAIT_CYC,
  parameter int unsigned ERRDET_WAIT_CYC = rdc_init_pkg::ERRDET_WAIT_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   start,
  output var  logic                   busy_q,
  output var  logic                   done_q,
  output var  logic [4:0]             step_q,
  output var  logic                   dev_req_q,
  output var  rdc_init_pkg::dev_cmd_s dev_cmd_q,
  input  wire logic                   dev_ack,
  input  wire logic [31:0]            dev_rdata
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (INIT_WAIT_CYC < 1 || ADCCAL_WAIT_CYC < 1 || TABLE_WAIT_CYC < 1 ||
      INTEG_WAIT_CYC < 1 || ERRDET_WAIT_CYC < 1) begin : g_bad_wait
    $error("rdc_init_seq: every wait count must be at least one cycle");
  end

  // ----------------------------------------------------------------------
  // Step table
  // ----------------------------------------------------------------------
  // Request bits are ORed into the register's other set bits; the converter clears them itself
  function automatic rdc_init_pkg::step_s mk(input rdc_init_pkg::op_e op,
                                             input logic [7:0] addr,
                                             input logic [31:0] data,
                                             input rdc_init_pkg::wait_sel_e wsel);
    rdc_init_pkg::step_s s;
    s.op   = op;
    s.addr = addr;
    s.data = data;
    s.wsel = wsel;
    return s;
  endfunction

  function automatic logic [31:0] bitw(input int unsigned pos);
    return 32'h00000001 << pos;
  endfunction

  function automatic rdc_init_pkg::step_s step_rom(input logic [4:0] idx);
    rdc_init_pkg::step_s s;
    logic [31:0] cfg_b;
    logic [31:0] mon;
    cfg_b = rdc_init_pkg::ERROR_CFG_B_VAL;
    mon   = bitw(rdc_init_pkg::MONITOR_OUT_EN_BIT);
    s = mk(rdc_init_pkg::OP_WAIT, 8'h00, rdc_init_pkg::ZERO_VAL, rdc_init_pkg::W_INIT);
    case (idx)
      5'h00: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::EXCITATION_SELECT_REG,
                    rdc_init_pkg::EXCITATION_10K_VAL, rdc_init_pkg::W_INIT); // RL1
      5'h01: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::LOOP_GAIN_REG_A,
                    rdc_init_pkg::LOOP_GAIN_A_VAL, rdc_init_pkg::W_INIT); // RL2
      5'h02: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::LOOP_GAIN_REG_B,
                    rdc_init_pkg::LOOP_GAIN_B_VAL, rdc_init_pkg::W_INIT); // RL2
      5'h03: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ERROR_CONFIG_REG_A,
                    rdc_init_pkg::ERROR_CFG_A_VAL, rdc_init_pkg::W_INIT); // RL3
      5'h04: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ERROR_CONFIG_REG_B,
                    cfg_b, rdc_init_pkg::W_INIT); // RL3
      5'h05: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::DIGITAL_CALC_REG,
                    rdc_init_pkg::DIGITAL_CALC_VAL, rdc_init_pkg::W_INIT); // RL4
      5'h06: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::MONITOR_GAIN_CTRL_REG,
                    mon, rdc_init_pkg::W_INIT); // RL4
      // Analog stop bit written as zero: the whole word is zero
      5'h07: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ANALOG_RUN_CTRL_REG,
                    rdc_init_pkg::ZERO_VAL, rdc_init_pkg::W_INIT); // RL5
      5'h08: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ERROR_CONFIG_REG_B,
                    cfg_b | bitw(rdc_init_pkg::INIT_REQUEST_BIT), rdc_init_pkg::W_INIT); // RL6
      5'h09: s = mk(rdc_init_pkg::OP_WAIT, 8'h00, rdc_init_pkg::ZERO_VAL,
                    rdc_init_pkg::W_INIT); // RL6
      5'h0A: s = mk(rdc_init_pkg::OP_POLL, rdc_init_pkg::ERROR_CONFIG_REG_B,
                    rdc_init_pkg::ZERO_VAL, rdc_init_pkg::W_INIT); // RL7
      5'h0B: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ADC_CAL_SETTING_REG,
                    rdc_init_pkg::ZERO_VAL, rdc_init_pkg::W_INIT); // RL8
      5'h0C: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ADC_CAL_CTRL_REG,
                    bitw(rdc_init_pkg::ADC_CAL_START_BIT), rdc_init_pkg::W_INIT); // RL8
      5'h0D: s = mk(rdc_init_pkg::OP_WAIT, 8'h00, rdc_init_pkg::ZERO_VAL,
                    rdc_init_pkg::W_ADCCAL); // RL8
      5'h0E: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::TABLE_CORRECTION_REG,
                    bitw(rdc_init_pkg::TABLE_CORRECTION_ENABLE_BIT),
                    rdc_init_pkg::W_INIT); // RL9
      5'h0F: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::TABLE_CORRECTION_REG,
                    bitw(rdc_init_pkg::TABLE_CORRECTION_ENABLE_BIT) |
                    bitw(rdc_init_pkg::TABLE_CORRECTION_START_BIT),
                    rdc_init_pkg::W_INIT); // RL9
      5'h10: s = mk(rdc_init_pkg::OP_WAIT, 8'h00, rdc_init_pkg::ZERO_VAL,
                    rdc_init_pkg::W_TABLE); // RL9
      5'h11: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::MONITOR_GAIN_CTRL_REG,
                    mon | bitw(rdc_init_pkg::AMP_UNITY_GAIN_BIT), rdc_init_pkg::W_INIT); // RL10
      5'h12: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ERROR_CONFIG_REG_B,
                    cfg_b | bitw(rdc_init_pkg::INTEGRATOR_RESET_BIT),
                    rdc_init_pkg::W_INIT); // RL10
      5'h13: s = mk(rdc_init_pkg::OP_WAIT, 8'h00, rdc_init_pkg::ZERO_VAL,
                    rdc_init_pkg::W_INTEG); // RL10
      5'h14: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::DIGITAL_CALC_REG,
                    rdc_init_pkg::DIGITAL_CALC_VAL | bitw(rdc_init_pkg::AMP_INVERT_BIT),
                    rdc_init_pkg::W_INIT); // RL11
      5'h15: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ERROR_CONFIG_REG_B,
                    cfg_b | bitw(rdc_init_pkg::ERROR_DETECT_ENABLE_BIT),
                    rdc_init_pkg::W_INIT); // RL12
      5'h16: s = mk(rdc_init_pkg::OP_WAIT, 8'h00, rdc_init_pkg::ZERO_VAL,
                    rdc_init_pkg::W_ERRDET); // RL12
      5'h17: s = mk(rdc_init_pkg::OP_WRITE, rdc_init_pkg::ERROR_CONFIG_REG_B,
                    cfg_b | bitw(rdc_init_pkg::ERROR_DETECT_ENABLE_BIT) |
                    bitw(rdc_init_pkg::ERROR_STATUS_RESET_BIT), rdc_init_pkg::W_INIT); // RL12
      default: s = mk(rdc_init_pkg::OP_WAIT, 8'h00, rdc_init_pkg::ZERO_VAL,
                      rdc_init_pkg::W_INIT);
    endcase
    return s;
  endfunction

  // Wait length, in cycles, for each wait slot
  function automatic logic [31:0] wait_len(input rdc_init_pkg::wait_sel_e w);
    case (w)
      rdc_init_pkg::W_INIT:   return INIT_WAIT_CYC;
      rdc_init_pkg::W_ADCCAL: return ADCCAL_WAIT_CYC;
      rdc_init_pkg::W_TABLE:  return TABLE_WAIT_CYC;
      rdc_init_pkg::W_INTEG:  return INTEG_WAIT_CYC;
      rdc_init_pkg::W_ERRDET: return ERRDET_WAIT_CYC;
      default:                return 32'h00000001;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Data goes through the same two stages as ack, so it settles no later than ack
  logic        ack_m_q;
  logic        ack_s_q;
  logic [31:0] rdata_m_q;
  logic [31:0] rdata_s_q;

  always_ff @(posedge sys_clk) begin
    ack_m_q   <= dev_ack;
    ack_s_q   <= ack_m_q;
    rdata_m_q <= dev_rdata;
    rdata_s_q <= rdata_m_q;
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_REQ   = 3'b010,
    ST_REL   = 3'b011,
    ST_WAIT  = 3'b100
  } state_e;

  state_e              state_q;
  logic [31:0]         wait_cnt_q;
  logic                poll_busy_q;
  rdc_init_pkg::step_s cur;

  assign cur = step_rom(step_q);

  // Main control; a start while busy is ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      step_q      <= 5'h00;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      dev_req_q   <= 1'b0;
      dev_cmd_q   <= '0;
      wait_cnt_q  <= 32'h00000000;
      poll_busy_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            busy_q  <= 1'b1;
            step_q  <= 5'h00;
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (cur.op == rdc_init_pkg::OP_WAIT) begin
            wait_cnt_q <= wait_len(cur.wsel); // RL13
            state_q    <= ST_WAIT;
          end else begin
            dev_cmd_q.we    <= (cur.op == rdc_init_pkg::OP_WRITE);
            dev_cmd_q.addr  <= cur.addr;
            dev_cmd_q.wdata <= cur.data;
            dev_req_q       <= 1'b1;
            state_q         <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (ack_s_q) begin
            dev_req_q   <= 1'b0;
            poll_busy_q <= rdata_s_q[rdc_init_pkg::INIT_REQUEST_BIT];
            state_q     <= ST_REL;
          end
        end
        ST_REL: begin
          if (!ack_s_q) begin
            if (cur.op == rdc_init_pkg::OP_POLL && poll_busy_q) begin
              state_q <= ST_LOAD; // RL7
            end else if (step_q == rdc_init_pkg::LAST_STEP) begin
              busy_q  <= 1'b0;
              done_q  <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              step_q  <= step_q + 5'h01;
              state_q <= ST_LOAD;
            end
          end
        end
        ST_WAIT: begin
          // Waits never end the sequence, so no last-step check here
          if (wait_cnt_q <= 32'h00000001) begin
            step_q  <= step_q + 5'h01; // RL13
            state_q <= ST_LOAD;
          end else begin
            wait_cnt_q <= wait_cnt_q - 32'h00000001; // RL13
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // rdc_init_seq

`default_nettype wire

// File: tb/rdc_dev_model.sv
// Behavioural converter answering the sequencer's four-phase register accesses.
// Assumes a shared clock; ack and read data change just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module rdc_dev_model #(
  parameter int unsigned POLL_N = 2
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   req,
  input  wire rdc_init_pkg::dev_cmd_s cmd,
  input  wire logic [3:0]             ack_dly,
  output var  logic                   ack,
  output var  logic [31:0]            rdata
);
  logic [31:0] regs_q [16];
  logic [3:0]  dly_q;
  logic [3:0]  pend_q;
  // Slow or prompt ack; read data toggles once released so stale values never pass
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack    <= 1'b0;
      dly_q  <= 4'h0;
      pend_q <= 4'h0;
      rdata  <= 32'h5A5A5A5A;
    end else if (!req) begin
      ack   <= 1'b0;
      dly_q <= 4'h0;
      rdata <= ~rdata;
    end else if (!ack && dly_q < ack_dly) begin
      dly_q <= dly_q + 4'h1;
    end else if (!ack) begin
      ack <= 1'b1;
      if (cmd.we) begin
        regs_q[cmd.addr[3:0]] <= cmd.wdata;
        if (cmd.addr == 8'h04 && cmd.wdata[0]) pend_q <= 4'(POLL_N);
      end else begin
        rdata <= regs_q[cmd.addr[3:0]];
        // Init bit clears only after POLL_N polls, so the host must keep reading
        if (cmd.addr == 8'h04 && pend_q == 4'h1) regs_q[4][0] <= 1'b0;
        if (pend_q != 4'h0) pend_q <= pend_q - 4'h1;
      end
    end
  end
endmodule // rdc_dev_model
`default_nettype wire

// File: tb/rdc_init_seq_monitor.sv
// Checker for the converter start-up sequencer, watching its ports only.
// Assumes it is bound into the sequencer with INIT_WAIT_CYC handed on.
`timescale 1ns/100ps
`default_nettype none
module rdc_init_seq_monitor #(
  parameter int unsigned INIT_WAIT_CYC = 5
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   start,
  input wire logic                   busy_q,
  input wire logic                   done_q,
  input wire logic [4:0]             step_q,
  input wire logic                   dev_req_q,
  input wire rdc_init_pkg::dev_cmd_s dev_cmd_q,
  input wire logic                   dev_ack,
  input wire logic [31:0]            dev_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Idle gap before each request; the init write is remembered so its wait can be measured
  logic [15:0] gap_q;
  logic        init_q;
  always_ff @(posedge sys_clk) begin
    gap_q  <= (rst || dev_req_q) ? 16'h0000 : gap_q + 16'h0001;
    init_q <= rst ? 1'b0 : dev_req_q ? (dev_cmd_q == {1'b1, 8'h04, 32'hB0000001}) : init_q;
  end
  sequence s_ack_seen;
    dev_req_q && dev_ack;
  endsequence
  sequence s_released;
    !dev_req_q [*3];
  endsequence
  a_reset_clears_all: assert property ($fell(rst) |-> !busy_q && !done_q && !dev_req_q
    && step_q == 5'h00 && dev_cmd_q == 41'h00000000000) else $error("outputs not cleared");
  a_req_held: assert property (dev_req_q && !dev_ack |=> dev_req_q)
    else $error("request dropped before ack");
  a_cmd_stable: assert property (dev_req_q && $past(dev_req_q) |-> $stable(dev_cmd_q))
    else $error("command moved under request");
  a_ack_release: assert property (s_ack_seen |-> ##[1:4] !dev_req_q)
    else $error("request not released after ack");
  a_req_spacing: assert property ($fell(dev_req_q) |-> s_released)
    else $error("requests too close");
  a_done_pulse: assert property (done_q |=> !done_q) else $error("done longer than one cycle");
  a_done_ends_busy: assert property (done_q |-> !busy_q && $past(busy_q))
    else $error("done without busy ending");
  a_start_taken: assert property (start && !busy_q && !done_q |=> busy_q)
    else $error("start not taken");
  a_req_in_busy: assert property (dev_req_q |-> busy_q) else $error("request while idle");
  a_init_wait: assert property ($rose(dev_req_q) && init_q |-> gap_q >= INIT_WAIT_CYC)
    else $error("init wait too short");
endmodule // rdc_init_seq_monitor
`default_nettype wire

// File: tb/rdc_init_seq_tb.sv
// Self-checking bench: runs the start-up sequence against the converter model.
// Assumes short wait parameters so whole runs stay a few hundred cycles.
`timescale 1ns/100ps
`default_nettype none
module rdc_init_seq_tb;
  // Waits longer than the five-cycle handshake turnaround, so a skipped wait shows in the gaps
  localparam int WI = 12, WA = 13, WT = 14, WK = 15, WE = 16;
  localparam logic [39:0] WR[18] = '{40'h000B0F0410, 40'h0100020017, 40'h0200011B01,
    40'h03021A2933, 40'h04B0000000, 40'h0500020024, 40'h0600000001, 40'h0700000000,
    40'h04B0000001, 40'h0800000000, 40'h0900000001, 40'h0A00000001, 40'h0A00000003,
    40'h0600000003, 40'h04B0000002, 40'h0500020124, 40'h04B0000004, 40'h04B000000C};
  logic                   sys_clk, rst, start, ack, busy_q, done_q, dev_req_q, req_p;
  logic [3:0]             ack_dly;
  logic [4:0]             step_q;
  logic [31:0]            rdata;
  rdc_init_pkg::dev_cmd_s dev_cmd_q;
  rdc_init_pkg::dev_cmd_s acc_log[$];
  int                     gaps[$];
  int                     cyc, fall_c, miscompares, comparisons;
  rdc_init_seq #(.INIT_WAIT_CYC(WI), .ADCCAL_WAIT_CYC(WA), .TABLE_WAIT_CYC(WT),
    .INTEG_WAIT_CYC(WK), .ERRDET_WAIT_CYC(WE)) i_rdc_init_seq (.sys_clk(sys_clk),
    .rst(rst), .start(start), .busy_q(busy_q), .done_q(done_q), .step_q(step_q),
    .dev_req_q(dev_req_q), .dev_cmd_q(dev_cmd_q), .dev_ack(ack), .dev_rdata(rdata));
  rdc_dev_model #(.POLL_N(2)) i_rdc_dev_model (.sys_clk(sys_clk), .rst(rst),
    .req(dev_req_q), .cmd(dev_cmd_q), .ack_dly(ack_dly), .ack(ack), .rdata(rdata));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Log every access with its idle gap; also the hang limit
  always @(negedge sys_clk) begin
    cyc++;
    if (dev_req_q === 1'b1 && req_p !== 1'b1) begin
      acc_log.push_back(dev_cmd_q);
      gaps.push_back(cyc - fall_c);
    end
    if (dev_req_q !== 1'b1 && req_p === 1'b1) fall_c = cyc;
    req_p = dev_req_q;
    if (cyc > 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  // One full run; a second start in mid-run must be ignored
  task automatic run(input logic [3:0] d);
    int n, k, need;
    ack_dly <= d;
    acc_log.delete();
    gaps.delete();
    @(posedge sys_clk) start <= 1'b1;
    @(posedge sys_clk) start <= 1'b0;
    repeat (30) @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk) start <= 1'b0;
    n = 0;
    while (done_q !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check(41'(done_q), 41'h1);
    repeat (10) @(negedge sys_clk);
    check(41'({done_q, busy_q}), 41'h0);
    check(41'(acc_log.size()), 41'h00000000015);
    k = 0;
    need = 0;
    for (int i = 0; i < 18; i++) begin
      check(acc_log[k], {1'b1, WR[i]});
      check(41'(gaps[k] >= need), 41'h1);
      k++;
      need = (i == 8) ? WI : (i == 10) ? WA : (i == 12) ? WT : (i == 14) ? WK : 0;
      need = (i == 16) ? WE : need;
      for (int p = 0; p < ((i == 8) ? 3 : 0); p++) begin
        check(41'({acc_log[k].we, acc_log[k].addr}), 41'h00000000004);
        check(41'(gaps[k] >= need), 41'h1);
        need = 0;
        k++;
      end
    end
  endtask
  initial begin
    rst = 1'b1;
    start = 1'b0;
    ack_dly = 4'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    run(4'h0);
    run(4'h3);
    @(posedge sys_clk) start <= 1'b1;
    @(posedge sys_clk) start <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check(41'({busy_q, done_q, dev_req_q, step_q}), 41'h0);
    check(dev_cmd_q, 41'h0);
    @(posedge sys_clk) rst <= 1'b0;
    run(4'h1);
    end_of_test();
  end
endmodule // rdc_init_seq_tb
bind rdc_init_seq rdc_init_seq_monitor #(.INIT_WAIT_CYC(INIT_WAIT_CYC)) i_rdc_init_seq_monitor (
  .sys_clk(sys_clk), .rst(rst), .start(start), .busy_q(busy_q), .done_q(done_q),
  .step_q(step_q), .dev_req_q(dev_req_q), .dev_cmd_q(dev_cmd_q), .dev_ack(dev_ack),
  .dev_rdata(dev_rdata));
`default_nettype wire
